// >>> rtl/cel_event_pulse.sv
// event pulse generator toward the host: event qualification, one pulse
// per one-second slot once initialisation is done, sticky status with mask and level interrupt
// assumes all gauge inputs come from logic on i_clk; register port is plain
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

module cel_event_pulse
    import cel_pkg::*;
#(
    parameter int P_CYC_PER_MS = CYC_PER_MS,
    parameter logic [7:0] P_CE_MASK = 8'h01
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [7:0] o_rd_data,
    input wire logic i_init_done,
    input wire logic [7:0] i_level,
    input wire logic [1:0] i_dir,
    input wire logic i_battery_sensed,
    input wire logic i_host_insert,
    input wire logic i_host_remove,
    input wire logic i_peak_update,
    input wire logic [7:0] i_fault_reg,
    input wire logic [7:0] i_ctrl_reg,
    input wire logic [15:0] i_target_voltage,
    input wire logic [15:0] i_target_current,
    input wire logic i_meas_start,
    output logic o_event_pulse,
    output logic o_irq,
    output logic o_battery_present
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cfg_b;
        logic [7:0] cfg_d;
        logic [7:0] cfg_e;
        logic [7:0] cfg_x;
        logic [7:0] step;
        logic [7:0] set_th;
        logic [7:0] clr_th;
        logic [7:0] mask;
        logic [7:0] status;
        logic [7:0] prev_level;
        logic [7:0] prev_fault;
        logic [7:0] prev_ce;
        logic [15:0] prev_volt;
        logic [15:0] prev_curr;
        logic primed;
        logic present;
        logic pend_short;
        logic pend_long;
        cel_fsm_e fsm;
        logic [WIDTH_W-1:0] width_cnt;
        logic [SLOT_W-1:0] slot_cnt;
        logic slot_used;
        logic pulse;
        logic irq;
        logic [7:0] rd_data;
    } cel_main_s;

    cel_main_s s_q;
    cel_main_s s_d;
    logic tick;
    logic [7:0] ev;
    logic low_hit;
    logic profile_chg;
    logic slot_free;
    logic present_d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    cel_step_if step_bus ();

    cel_ms_tick #(
        .P_CYC_PER_MS(P_CYC_PER_MS)
    ) u_tick (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .o_tick(tick)
    );

    cel_step_det u_step (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .bus(step_bus)
    );

    assign step_bus.level = i_level;
    assign step_bus.step = s_q.step;
    assign step_bus.dir = cel_dir_e'(i_dir);

    // ------------------------------------------------------------
    // event qualification
    // ------------------------------------------------------------
    always_comb begin
        // presence follows the sensor, or the host when detection is off
        present_d = s_q.present;
        if (s_q.cfg_b[B_INSERT_DET]) begin
            present_d = i_battery_sensed;
        end else if (i_host_insert) begin
            present_d = 1'b1;
        end else if (i_host_remove) begin
            present_d = 1'b0;
        end
        low_hit = s_q.primed && i_level != s_q.prev_level && (i_level == s_q.set_th || i_level == s_q.clr_th);
        profile_chg = s_q.primed && (i_target_voltage != s_q.prev_volt || i_target_current != s_q.prev_curr
                      || (i_ctrl_reg & P_CE_MASK) != s_q.prev_ce);
        ev = 8'h00;
        ev[EV_STEP] = step_bus.step_evt;
        ev[EV_LOW] = low_hit && s_q.cfg_b[B_LOW_INT];
        ev[EV_STATE] = step_bus.state_evt && s_q.cfg_d[D_STATE_INT];
        ev[EV_REMOVAL] = s_q.present && !present_d && s_q.cfg_x[X_REMOVAL_INT]
                         && s_q.cfg_b[B_INSERT_DET];
        ev[EV_PEAK] = i_peak_update && s_q.cfg_e[E_PEAK_INT];
        ev[EV_MEAS] = i_meas_start && (i_init_done || s_q.cfg_x[X_FIRST_MEAS]);
        ev[EV_FAULT] = s_q.primed && i_fault_reg != s_q.prev_fault && s_q.cfg_x[X_FAULT_INT];
        ev[EV_PROFILE] = profile_chg && s_q.cfg_b[B_PROFILE_INT];
        // the slot limit starts only once initialisation is over
        slot_free = !s_q.slot_used || !i_init_done;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rd_data = 8'h00;
        s_d.primed = 1'b1;
        s_d.prev_level = i_level;
        s_d.prev_fault = i_fault_reg;
        s_d.prev_ce = i_ctrl_reg & P_CE_MASK;
        s_d.prev_volt = i_target_voltage;
        s_d.prev_curr = i_target_current;

        s_d.present = present_d;

        // register writes
        if (i_wr_en) begin
            case (i_addr)
                OFS_CFG_B: begin
                    s_d.cfg_b = i_wr_data;
                end
                OFS_CFG_D: begin
                    s_d.cfg_d = i_wr_data;
                end
                OFS_CFG_E: begin
                    s_d.cfg_e = i_wr_data;
                end
                OFS_CFG_X: begin
                    s_d.cfg_x = i_wr_data;
                end
                OFS_STEP: begin
                    s_d.step = i_wr_data;
                end
                OFS_SET_TH: begin
                    s_d.set_th = i_wr_data;
                end
                OFS_CLR_TH: begin
                    s_d.clr_th = i_wr_data;
                end
                OFS_MASK: begin
                    s_d.mask = i_wr_data;
                end
                default: begin
                end
            endcase
        end

        // register reads; status is cleared by its read, new events win
        if (i_rd_en) begin
            case (i_addr)
                OFS_CFG_B: s_d.rd_data = s_q.cfg_b;
                OFS_CFG_D: s_d.rd_data = s_q.cfg_d;
                OFS_CFG_E: s_d.rd_data = s_q.cfg_e;
                OFS_CFG_X: s_d.rd_data = s_q.cfg_x;
                OFS_STEP: s_d.rd_data = s_q.step;
                OFS_SET_TH: s_d.rd_data = s_q.set_th;
                OFS_CLR_TH: s_d.rd_data = s_q.clr_th;
                OFS_MASK: s_d.rd_data = s_q.mask;
                OFS_STATUS: begin
                    s_d.rd_data = s_q.status;
                    s_d.status = 8'h00;
                end
                OFS_STATE: s_d.rd_data = {2'b00, s_q.present, s_q.slot_used, s_q.pend_long, s_q.pend_short,
                                          s_q.fsm};
                default: s_d.rd_data = 8'h00;
            endcase
        end
        s_d.status = s_d.status | ev;

        // one-second slots run on the millisecond tick
        if (tick) begin
            if (s_q.slot_cnt == SLOT_W'(SLOT_TICKS - 1)) begin
                s_d.slot_cnt = '0;
                s_d.slot_used = 1'b0;
            end else begin
                s_d.slot_cnt = s_q.slot_cnt + SLOT_W'(1);
            end
        end

        // pulse machine; pulses start on a tick so widths are whole ms
        case (s_q.fsm)
            ST_IDLE: begin
                if (tick && slot_free && (s_q.pend_short || s_q.pend_long)) begin
                    s_d.fsm = ST_PULSE;
                    s_d.pulse = 1'b1;
                    s_d.slot_used = 1'b1;
                    // one pulse stands for all pending events
                    s_d.pend_short = 1'b0;
                    s_d.pend_long = 1'b0;
                    if (s_q.pend_long) begin
                        s_d.width_cnt = WIDTH_W'(LONG_PULSE_TICKS);
                    end else begin
                        s_d.width_cnt = WIDTH_W'(SHORT_PULSE_TICKS);
                    end
                end
            end
            ST_PULSE: begin
                if (tick) begin
                    if (s_q.width_cnt == WIDTH_W'(1)) begin
                        s_d.fsm = ST_IDLE;
                        s_d.pulse = 1'b0;
                        s_d.width_cnt = '0;
                    end else begin
                        s_d.width_cnt = s_q.width_cnt - WIDTH_W'(1);
                    end
                end
            end
            default: begin
                s_d.fsm = ST_IDLE;
                s_d.pulse = 1'b0;
            end
        endcase

        // events of this cycle survive a take in the same cycle
        s_d.pend_long = s_d.pend_long | ev[EV_MEAS];
        s_d.pend_short = s_d.pend_short | (|(ev & ~(8'h01 << EV_MEAS)));
        s_d.irq = |(s_d.status & s_d.mask);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_q <= '0;
            s_q.cfg_b <= RST_CFG_B;
            s_q.cfg_d <= RST_CFG_D;
            s_q.cfg_e <= RST_CFG_E;
            s_q.cfg_x <= RST_CFG_X;
            s_q.step <= RST_STEP;
            s_q.set_th <= RST_SET_TH;
            s_q.clr_th <= RST_CLR_TH;
            s_q.mask <= RST_MASK;
            s_q.fsm <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rd_data = s_q.rd_data;
    assign o_event_pulse = s_q.pulse;
    assign o_irq = s_q.irq;
    assign o_battery_present = s_q.present;

endmodule

// >>> include/cel_pkg.sv
// constants and types of the charge event pulse generator
// assumes a single 50 MHz clock and a 1 ms tick made from it
package cel_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int TICK_MS = 1;
    localparam int SLOT_TIME_MS = 1000;
    localparam int SHORT_PULSE_MS = 1;
    localparam int LONG_PULSE_MS = 165;
    localparam int SLOT_TICKS = SLOT_TIME_MS / TICK_MS;
    localparam int SHORT_PULSE_TICKS = SHORT_PULSE_MS / TICK_MS;
    localparam int LONG_PULSE_TICKS = LONG_PULSE_MS / TICK_MS;
    localparam int SLOT_W = 10;
    localparam int WIDTH_W = 8;

    // ------------------------------------------------------------
    // charge level
    // ------------------------------------------------------------
    localparam logic [7:0] LEVEL_FULL = 8'h64;
    localparam logic [7:0] LEVEL_EMPTY = 8'h00;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CFG_B = 4'h0;
    localparam logic [3:0] OFS_CFG_D = 4'h1;
    localparam logic [3:0] OFS_CFG_E = 4'h2;
    localparam logic [3:0] OFS_CFG_X = 4'h3;
    localparam logic [3:0] OFS_STEP = 4'h4;
    localparam logic [3:0] OFS_SET_TH = 4'h5;
    localparam logic [3:0] OFS_CLR_TH = 4'h6;
    localparam logic [3:0] OFS_STATUS = 4'h7;
    localparam logic [3:0] OFS_MASK = 4'h8;
    localparam logic [3:0] OFS_STATE = 4'h9;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int B_INSERT_DET = 0;
    localparam int B_LOW_INT = 1;
    localparam int B_PROFILE_INT = 2;
    localparam int D_STATE_INT = 5;
    localparam int E_PEAK_INT = 5;
    localparam int X_REMOVAL_INT = 0;
    localparam int X_FIRST_MEAS = 1;
    localparam int X_FAULT_INT = 2;

    // event bits of status and mask
    localparam int EV_STEP = 0;
    localparam int EV_LOW = 1;
    localparam int EV_STATE = 2;
    localparam int EV_REMOVAL = 3;
    localparam int EV_PEAK = 4;
    localparam int EV_MEAS = 5;
    localparam int EV_FAULT = 6;
    localparam int EV_PROFILE = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CFG_B = 8'h00;
    localparam logic [7:0] RST_CFG_D = 8'hC3;
    localparam logic [7:0] RST_CFG_E = 8'h73;
    localparam logic [7:0] RST_CFG_X = 8'h00;
    localparam logic [7:0] RST_STEP = 8'h00;
    localparam logic [7:0] RST_SET_TH = 8'h00;
    localparam logic [7:0] RST_CLR_TH = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DIR_RELAX = 2'b00,
        DIR_CHG = 2'b01,
        DIR_DSG = 2'b10
    } cel_dir_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PULSE = 2'b01
    } cel_fsm_e;

endpackage

// >>> include/cel_step_if.sv
// charge level and direction toward the step detector, its events back
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface cel_step_if;
    import cel_pkg::*;
    logic [7:0] level;
    logic [7:0] step;
    cel_dir_e dir;
    logic step_evt;
    logic state_evt;
    modport main (output level, output step, output dir, input step_evt, input state_evt);
    modport det (input level, input step, input dir, output step_evt, output state_evt);
endinterface

// >>> rtl/cel_ms_tick.sv
// one-cycle tick every millisecond
// assumes a free running clock; the count is a parameter to shorten runs
`timescale 1ns/1ps
module cel_ms_tick
    import cel_pkg::*;
#(
    parameter int P_CYC_PER_MS = CYC_PER_MS
) (
    input wire logic i_clk,
    input wire logic i_srst,
    output logic o_tick
);

    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } cel_tick_s;

    cel_tick_s s_q;
    cel_tick_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == 32'(P_CYC_PER_MS - 1)) begin
            s_d.cnt = 32'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 32'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_tick = s_q.tick;

endmodule

// >>> rtl/cel_step_det.sv
// charge step crossings and charge/discharge turn detection
// assumes level and direction come from logic on the same clock
`timescale 1ns/1ps
module cel_step_det
    import cel_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    cel_step_if.det bus
);

    typedef struct packed {
        logic [7:0] prev;
        logic primed;
        cel_dir_e last_dir;
        logic have_dir;
        logic step_evt;
        logic state_evt;
    } cel_det_s;

    cel_det_s s_q;
    cel_det_s s_d;
    logic [7:0] cur;
    logic [7:0] q_prev;
    logic [7:0] q_cur;

    // a point is crossed when the step index of the level falls on charge or rises on discharge, or on discharge when the level reaches empty
    always_comb begin
        cur = (bus.level > LEVEL_FULL) ? LEVEL_FULL : bus.level;
        q_prev = 8'h00;
        q_cur = 8'h00;
        if (bus.step != 8'h00) begin
            q_prev = (LEVEL_FULL - s_q.prev) / bus.step;
            q_cur = (LEVEL_FULL - cur) / bus.step;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.step_evt = 1'b0;
        s_d.state_evt = 1'b0;
        if (s_q.primed && bus.step != 8'h00) begin
            if (bus.dir == DIR_CHG && q_cur < q_prev) begin
                s_d.step_evt = 1'b1;
            end
            if (bus.dir == DIR_DSG && (q_cur > q_prev || (cur == LEVEL_EMPTY && s_q.prev != LEVEL_EMPTY))) begin
                s_d.step_evt = 1'b1;
            end
        end
        // relaxation neither fires nor forgets the last direction
        if (bus.dir == DIR_CHG || bus.dir == DIR_DSG) begin
            if (s_q.have_dir && bus.dir != s_q.last_dir && bus.step != 8'h00) begin
                s_d.state_evt = 1'b1;
            end
            s_d.last_dir = bus.dir;
            s_d.have_dir = 1'b1;
        end
        s_d.prev = cur;
        s_d.primed = 1'b1;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.step_evt = s_q.step_evt;
    assign bus.state_evt = s_q.state_evt;

endmodule

// >>> verification/cel_event_pulse_asserts.sv
// port checker of the event pulse generator
// assumes binding onto cel_event_pulse, one clock domain
`timescale 1ns/1ps
module cel_event_pulse_asserts
    import cel_pkg::*;
#(
    parameter int P_CYC_PER_MS = CYC_PER_MS
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [3:0] i_addr,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] o_rd_data,
    input wire logic i_battery_sensed,
    input wire logic i_host_insert,
    input wire logic o_event_pulse,
    input wire logic o_irq,
    input wire logic o_battery_present
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    localparam int W_S = SHORT_PULSE_TICKS * P_CYC_PER_MS;
    localparam int W_L = LONG_PULSE_TICKS * P_CYC_PER_MS;
    int hi_q;

    // counts high cycles of the pulse, cleared while low
    always_ff @(posedge i_clk) begin
        if (i_srst || !o_event_pulse) begin
            hi_q <= 0;
        end else begin
            hi_q <= hi_q + 1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_start;
        !o_event_pulse ##1 o_event_pulse;
    endsequence

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_reset_quiet: assert property (disable iff (1'b0)
        i_srst |=> !o_event_pulse && !o_irq && o_rd_data == 8'h00 && !o_battery_present)
        else $error("outputs not quiet in reset");
    a_rd_idle_zero: assert property (!$past(i_rd_en) |-> o_rd_data == 8'h00)
        else $error("read data without read");
    a_unmapped_read: assert property (i_rd_en && i_addr > OFS_STATE |=> o_rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_state_read: assert property (i_rd_en && i_addr == OFS_STATE |=>
        o_rd_data[7:6] == 2'b00 && o_rd_data[5] == $past(o_battery_present))
        else $error("state read wrong");
    a_pulse_hold: assert property (s_start |-> o_event_pulse [*4])
        else $error("pulse shorter than 1 ms");
    a_width_exact: assert property (
        $fell(o_event_pulse) && !$past(i_srst) |-> hi_q == W_S || hi_q == W_L)
        else $error("pulse width wrong");
    a_irq_fall_cause: assert property ($fell(o_irq) |->
        $past(i_rd_en && i_addr == OFS_STATUS) || $past(i_wr_en && i_addr == OFS_MASK))
        else $error("interrupt dropped without cause");
    a_present_cause: assert property ($rose(o_battery_present) |->
        $past(i_battery_sensed) || $past(i_host_insert) || $past(i_host_insert, 2))
        else $error("presence rose without cause");
endmodule

bind cel_event_pulse cel_event_pulse_asserts #(.P_CYC_PER_MS(P_CYC_PER_MS)) u_chk (
    .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .o_rd_data(o_rd_data), .i_battery_sensed(i_battery_sensed), .i_host_insert(i_host_insert),
    .o_event_pulse(o_event_pulse), .o_irq(o_irq), .o_battery_present(o_battery_present)
);

// >>> verification/cel_host_model.sv
// host side that receives event pulses: counts them, measures width and start
// assumes the pulse is active high and sampled on the device clock
`timescale 1ns/1ps
module cel_host_model (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_pulse,
    output int o_count,
    output int o_width,
    output int o_start
);
    int cyc_q;
    int hi_q;

    // count updates on the falling edge so width is final when seen
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cyc_q <= 0;
            hi_q <= 0;
            o_count <= 0;
            o_width <= 0;
            o_start <= 0;
        end else begin
            cyc_q <= cyc_q + 1;
            if (i_pulse) begin
                hi_q <= hi_q + 1;
                if (hi_q == 0) begin
                    o_start <= cyc_q;
                end
            end else if (hi_q != 0) begin
                o_width <= hi_q;
                o_count <= o_count + 1;
                hi_q <= 0;
            end
        end
    end
endmodule

// >>> verification/tb_top.sv
// self-checking bench of the event pulse generator
// assumes a 4-cycle millisecond so slots are 4000 cycles
`timescale 1ns/1ps
module tb_top;
    import cel_pkg::*;
    localparam int P = 4;
    localparam int W_S = SHORT_PULSE_TICKS * P;
    localparam int W_L = LONG_PULSE_TICKS * P;
    localparam int SLOT_C = SLOT_TICKS * P;
    logic i_clk = 0, i_srst = 1, i_wr_en = 0, i_rd_en = 0, i_init_done = 0;
    logic [3:0] i_addr = 0;
    logic [7:0] i_wr_data = 0, o_rd_data, i_level = 0, i_fault_reg = 0, i_ctrl_reg = 0;
    logic [1:0] i_dir = 0;
    logic i_battery_sensed = 0, i_host_insert = 0, i_host_remove = 0, i_peak_update = 0, i_meas_start = 0;
    logic [15:0] i_target_voltage = 0, i_target_current = 0;
    logic o_event_pulse, o_irq, o_battery_present;
    int cnt, wid, st, s1, errors = 0, num_checks = 0, tcyc = 0;
    logic [7:0] rv [10] = '{RST_CFG_B, RST_CFG_D, RST_CFG_E, RST_CFG_X, RST_STEP, RST_SET_TH,
        RST_CLR_TH, 8'h00, RST_MASK, 8'h00};
    logic [7:0] d;

    cel_event_pulse #(.P_CYC_PER_MS(P)) dut (.i_clk, .i_srst, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en,
        .o_rd_data, .i_init_done, .i_level, .i_dir, .i_battery_sensed, .i_host_insert, .i_host_remove,
        .i_peak_update, .i_fault_reg, .i_ctrl_reg, .i_target_voltage, .i_target_current, .i_meas_start,
        .o_event_pulse, .o_irq, .o_battery_present);
    cel_host_model host (.i_clk(i_clk), .i_srst(i_srst), .i_pulse(o_event_pulse), .o_count(cnt),
        .o_width(wid), .o_start(st));

    always #10 i_clk = ~i_clk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_wr_data <= v;
        i_wr_en <= 1'b1;
        @(posedge i_clk);
        i_wr_en <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd_en <= 1'b1;
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        @(posedge i_clk);
        d = o_rd_data;
        chk(d, exp);
    endtask
    task automatic ev_chk(input logic [7:0] exp);
        repeat (4) @(posedge i_clk);
        rdc(OFS_STATUS, exp);
    endtask
    // order: measure, peak, insert, remove
    task automatic fire(input logic [3:0] m);
        @(posedge i_clk);
        {i_meas_start, i_peak_update, i_host_insert, i_host_remove} <= m;
        @(posedge i_clk);
        {i_meas_start, i_peak_update, i_host_insert, i_host_remove} <= 4'h0;
    endtask
    // bounded wait: slot wait plus long pulse fits well inside
    task automatic wait_pulse(input int exp_w);
        int n;
        n = cnt;
        for (int k = 0; k < 9000 && cnt == n; k++) begin
            @(posedge i_clk);
        end
        chk(cnt, n + 1);
        chk(wid, exp_w);
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        tcyc++;
        if (tcyc == 60000) begin
            errors++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hC608));
        repeat (6) @(posedge i_clk);
        i_srst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rdc(i[3:0], rv[i]);
        end
        wr(OFS_STATUS, 8'hFF);
        rdc(OFS_STATUS, 8'h00);
        wr(4'hC, 8'h5A);
        rdc(4'hC, 8'h00);
        fire(4'h8);
        repeat (800) @(posedge i_clk);
        chk(cnt, 0);
        wr(OFS_CFG_X, 8'h02);
        fire(4'h8);
        wait_pulse(W_L);
        rdc(OFS_STATUS, 8'h20);
        i_init_done <= 1'b1;
        wr(OFS_MASK, 8'h10);
        fire(4'h4);
        ev_chk(8'h10);
        chk(o_irq, 1'b0);
        wr(OFS_MASK, 8'h00);
        fire(4'h4);
        repeat (3) @(posedge i_clk);
        wr(OFS_MASK, 8'h10);
        repeat (3) @(posedge i_clk);
        chk(o_irq, 1'b1);
        ev_chk(8'h10);
        repeat (3) @(posedge i_clk);
        chk(o_irq, 1'b0);
        wait_pulse(W_S);
        s1 = st;
        fire(4'h4);
        wait_pulse(W_S);
        chk((st % SLOT_C) < 3 * P || (st % SLOT_C) > SLOT_C - 3 * P, 1'b1);
        chk(st / SLOT_C != s1 / SLOT_C, 1'b1);
        fire(4'hC);
        wait_pulse(W_L);
        s1 = cnt;
        repeat (4500) @(posedge i_clk);
        chk(cnt, s1);
        rdc(OFS_STATUS, 8'h30);
        wr(OFS_MASK, 8'h00);
        wr(OFS_STEP, 8'h14);
        wr(OFS_SET_TH, 8'h0F);
        wr(OFS_CLR_TH, 8'h14);
        wr(OFS_CFG_B, 8'h07);
        wr(OFS_CFG_D, 8'hE3);
        wr(OFS_CFG_X, 8'h07);
        @(posedge i_clk);
        i_dir <= 2'h1;
        i_level <= 8'h32;
        repeat (6) @(posedge i_clk);
        rdc(OFS_STATUS, 8'h01);
        i_level <= 8'h3D;
        ev_chk(8'h01);
        i_dir <= 2'h2;
        ev_chk(8'h04);
        i_level <= 8'h3B;
        ev_chk(8'h01);
        i_dir <= 2'h0;
        ev_chk(8'h00);
        i_dir <= 2'h2;
        ev_chk(8'h00);
        i_level <= 8'h14;
        ev_chk(8'h03);
        i_level <= 8'h0F;
        ev_chk(8'h02);
        i_level <= 8'h00;
        ev_chk(8'h01);
        wr(OFS_CFG_B, 8'h05);
        i_dir <= 2'h0;
        i_level <= 8'h14;
        ev_chk(8'h00);
        wr(OFS_CFG_B, 8'h07);
        wr(OFS_CFG_D, 8'hC3);
        i_dir <= 2'h1;
        ev_chk(8'h00);
        i_battery_sensed <= 1'b1;
        ev_chk(8'h00);
        chk(o_battery_present, 1'b1);
        i_battery_sensed <= 1'b0;
        ev_chk(8'h08);
        wr(OFS_CFG_B, 8'h06);
        fire(4'h2);
        ev_chk(8'h00);
        chk(o_battery_present, 1'b1);
        fire(4'h1);
        ev_chk(8'h00);
        wr(OFS_CFG_E, 8'h53);
        fire(4'h4);
        ev_chk(8'h00);
        i_fault_reg <= i_fault_reg ^ (8'($urandom) | 8'h01);
        ev_chk(8'h40);
        i_target_voltage <= i_target_voltage ^ (16'($urandom) | 16'h0001);
        ev_chk(8'h80);
        i_target_current <= i_target_current ^ (16'($urandom) | 16'h0001);
        ev_chk(8'h80);
        i_ctrl_reg <= i_ctrl_reg ^ 8'h01;
        ev_chk(8'h80);
        i_ctrl_reg <= i_ctrl_reg ^ 8'h80;
        ev_chk(8'h00);
        end_of_test();
    end
endmodule
